// *** rtl/sysctrl_map.svh ***
// Clock frequency, release times, cycle counts and counter width of the reset and suspend control.
`ifndef SYSCTRL_MAP_SVH
`define SYSCTRL_MAP_SVH
`define CLK_FREQ_MHZ       50
`define NOGRST_RELEASE_US  1713
`define GRST_RELEASE_US    1720
`define NOGRST_CYCLES      (`NOGRST_RELEASE_US * `CLK_FREQ_MHZ)
`define GRST_CYCLES        (`GRST_RELEASE_US * `CLK_FREQ_MHZ)
`define INIT_CYCLES        16
`define CNT_WIDTH          17
`endif

// *** rtl/sysctrl_pkg.sv ***
// Types shared by the reset and suspend control.
package sysctrl_pkg;
    typedef enum logic [3:0] {
        ST_RESET   = 4'h1,
        ST_INIT    = 4'h2,
        ST_ACTIVE  = 4'h4,
        ST_SUSPEND = 4'h8
    } ctrl_state_t;
endpackage : sysctrl_pkg

// *** rtl/jtag_if.sv ***
// Interface carrying the JTAG input group and its gated copy.
`timescale 1ns/100ps
interface jtag_if;
    logic tck;
    logic tms;
    logic tdi;
    logic pass;
    logic g_tck;
    logic g_tms;
    logic g_tdi;
    modport ctrl (input tck, input tms, input tdi, input pass, output g_tck, output g_tms, output g_tdi);
    modport user (input g_tck, input g_tms, input g_tdi);
endinterface : jtag_if

// *** rtl/jtag_gate.sv ***
// Gate that blocks the JTAG inputs while suspended with test reset sampled low.
`timescale 1ns/100ps
module jtag_gate (
    input wire logic clk,
    input wire logic arst_n,
    jtag_if.ctrl     j
);
    // R5 block inputs
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            j.g_tck <= 1'b0;
            j.g_tms <= 1'b1;
            j.g_tdi <= 1'b0;
        end else begin
            j.g_tck <= j.pass ? j.tck : 1'b0;
            j.g_tms <= j.pass ? j.tms : 1'b1;
            j.g_tdi <= j.pass ? j.tdi : 1'b0;
        end
    end
endmodule : jtag_gate

// *** rtl/sysctrl_reset_suspend_ctrl.sv ***
// Reset release and suspend control of the configuration controller.
// Functional notes
// R1 - After power-up or hard reset be active, then suspend after init if configured.
// R2 - Suspend enable comes from a non-volatile bit set by image loading.
// R3 - Suspend bit not reachable from fabric or pins, only the image.
// R4 - Suspended with test reset high, JTAG programming and debug still work; code keeps JTAG blocked if test reset rises after power-up.
// R5 - Suspended with test reset low, all other JTAG inputs are ignored.
// R6 - Sample test reset only at power-up, hold until next power-up.
// R7 - Test reset high plus power cycle keeps the device active.
// R8 - Test reset high plus device reset leaves suspend for programming; code re-suspends after init, as test reset is sampled only at power-up.
// R9 - Normal operation restored only by an image with suspend bit cleared.
// R10 - Clocked from a dedicated 50 MHz on-chip oscillator.
// R11 - Fabric reset output is active low, derived from internal power-on reset.
// R12 - Power-on reset and device reset pin act regardless of suspend.
// R13 - When not programming, TAP lets user extension shift to fabric; code also holds it off in reset state and while JTAG is gated.
// R14 - Plain flops usable after 1713 us, reset flops and output after 1720 us.
// R15 - Global async reset acts during power-up or programming.
// R16 - Fabric reset output held low while internal power-on reset asserted.
`timescale 1ns/100ps
`include "sysctrl_map.svh"
module sysctrl_reset_suspend_ctrl #(
    // R10 oscillator cycle counts
    parameter int NOGRST_CYCLES = `NOGRST_CYCLES,
    parameter int GRST_CYCLES   = `GRST_CYCLES
) (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic device_reset_pin_n,
    input  wire logic test_reset_pin_b,
    input  wire logic image_load,
    input  wire logic image_suspend_bit,
    input  wire logic programming,
    input  wire logic tck,
    input  wire logic tms,
    input  wire logic tdi,
    output logic      internal_por_n,
    output logic      fabric_ready,
    output logic      fabric_reset_macro,
    output logic      global_async_reset,
    output logic      suspended,
    output logic      jtag_accept,
    output logic      user_tap_extension,
    output logic      user_tck,
    output logic      user_tms,
    output logic      user_tdi
);
    import sysctrl_pkg::*;

    // ------------------------------------------------------------
    // Non-volatile suspend bit and power-up sample
    // ------------------------------------------------------------
    // A blank device powers up with suspend disabled.
    logic                    suspend_cfg = 1'b0;
    logic                    trst_sampled;
    logic                    por_seen;
    ctrl_state_t             state;
    ctrl_state_t             next_state;
    logic [`CNT_WIDTH-1:0]   rel_cnt;
    logic [4:0]              init_cnt;
    jtag_if                  jb ();

    function automatic logic cnt_at(input logic [`CNT_WIDTH-1:0] c, input int lim);
        cnt_at = (c >= lim[`CNT_WIDTH-1:0]);
    endfunction : cnt_at

    // R2 image sets bit
    // R3 no other path
    // R9 cleared by image
    // The bit stands for a non-volatile cell, so no reset touches it and it survives power cycles.
    always_ff @(posedge clk) begin
        if (image_load) begin
            suspend_cfg <= image_suspend_bit;
        end
    end

    // R6 sample once
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            por_seen     <= 1'b0;
            trst_sampled <= 1'b0;
        end else if (!por_seen) begin
            por_seen     <= 1'b1;
            trst_sampled <= test_reset_pin_b;
        end
    end

    // ------------------------------------------------------------
    // Release counter after device reset pin deassertion
    // ------------------------------------------------------------
    // R12 reset regardless
    // R14 release count
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rel_cnt <= '0;
        end else if (!device_reset_pin_n) begin
            rel_cnt <= '0;
        end else if (!cnt_at(rel_cnt, GRST_CYCLES)) begin
            rel_cnt <= rel_cnt + 1'b1;
        end
    end

    // R14 release points
    // R11 active low
    // R16 follows internal
    // R15 global reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            internal_por_n     <= 1'b0;
            fabric_ready       <= 1'b0;
            fabric_reset_macro <= 1'b0;
            global_async_reset <= 1'b1;
        end else begin
            internal_por_n     <= device_reset_pin_n && cnt_at(rel_cnt, GRST_CYCLES);
            fabric_ready       <= device_reset_pin_n && cnt_at(rel_cnt, NOGRST_CYCLES);
            fabric_reset_macro <= internal_por_n && device_reset_pin_n && !programming;
            global_async_reset <= !(internal_por_n && device_reset_pin_n) || programming;
        end
    end

    // ------------------------------------------------------------
    // Controller state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            ST_RESET:   next_state = internal_por_n ? ST_INIT : ST_RESET;
            ST_INIT:    next_state = (init_cnt == 5'(`INIT_CYCLES)) ? ST_ACTIVE : ST_INIT;
            // R1 resuspend
            // R7 stay active
            ST_ACTIVE:  next_state = (suspend_cfg && !trst_sampled) ? ST_SUSPEND : ST_ACTIVE;
            ST_SUSPEND: next_state = suspend_cfg ? ST_SUSPEND : ST_ACTIVE;
            default:    next_state = ST_RESET;
        endcase
    end

    // R8 reset exits
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_RESET;
        end else if (!device_reset_pin_n) begin
            state <= ST_RESET;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            init_cnt <= '0;
        end else if (state == ST_INIT) begin
            init_cnt <= init_cnt + 1'b1;
        end else begin
            init_cnt <= '0;
        end
    end

    // ------------------------------------------------------------
    // JTAG gating and user TAP extension
    // ------------------------------------------------------------
    // R4 accept when high
    // R5 block when low
    assign jb.tck  = tck;
    assign jb.tms  = tms;
    assign jb.tdi  = tdi;
    assign jb.pass = (state != ST_SUSPEND) || trst_sampled;

    jtag_gate u_gate (
        .clk    (clk),
        .arst_n (arst_n),
        .j      (jb)
    );

    // R13 user extension
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            suspended          <= 1'b0;
            jtag_accept        <= 1'b0;
            user_tap_extension <= 1'b0;
            user_tck           <= 1'b0;
            user_tms           <= 1'b1;
            user_tdi           <= 1'b0;
        end else begin
            suspended          <= (state == ST_SUSPEND);
            jtag_accept        <= jb.pass;
            user_tap_extension <= jb.pass && !programming && (state != ST_RESET);
            user_tck           <= jb.g_tck;
            user_tms           <= jb.g_tms;
            user_tdi           <= jb.g_tdi;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    suspend_gate_a: assert property (@(posedge clk) disable iff (!arst_n) // R5
        (state == ST_SUSPEND && !trst_sampled) |=> !jtag_accept)
        else $error("JTAG accepted while gated");
    suspend_open_a: assert property (@(posedge clk) disable iff (!arst_n) // R4
        (state == ST_SUSPEND && trst_sampled) |=> jtag_accept)
        else $error("JTAG blocked with test reset high");
    fabric_por_a: assert property (@(posedge clk) disable iff (!arst_n) // R16
        !internal_por_n |=> !fabric_reset_macro)
        else $error("Fabric reset released early");
    devrst_hold_a: assert property (@(posedge clk) disable iff (!arst_n) // R12
        !device_reset_pin_n |=> ##1 (!internal_por_n && state == ST_RESET))
        else $error("Device reset ignored");
    stay_active_a: assert property (@(posedge clk) disable iff (!arst_n) // R7
        (state == ST_ACTIVE && trst_sampled) |=> state != ST_SUSPEND)
        else $error("Suspended despite test reset high");
    resuspend_a: assert property (@(posedge clk) disable iff (!arst_n) // R1
        (state == ST_ACTIVE && suspend_cfg && !trst_sampled && device_reset_pin_n) |=> state == ST_SUSPEND)
        else $error("Did not suspend");
    trst_hold_a: assert property (@(posedge clk) disable iff (!arst_n) // R6
        por_seen |=> $stable(trst_sampled))
        else $error("Test reset resampled");
    release_order_a: assert property (@(posedge clk) disable iff (!arst_n) // R14
        $rose(internal_por_n) |-> fabric_ready)
        else $error("Reset released before plain flops");
    global_async_reset_a: assert property (@(posedge clk) disable iff (!arst_n) // R15
        programming |=> global_async_reset)
        else $error("Global reset not applied while programming");
endmodule : sysctrl_reset_suspend_ctrl

// *** sim/jtag_prog_model.sv ***
// Behavioural external JTAG programmer driving the test port and test reset pin.
`timescale 1ns/100ps
module jtag_prog_model (
    input  wire logic clk,
    input  wire logic run,
    input  wire logic hold_trst,
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    output logic      test_reset_pin_b
);
    assign test_reset_pin_b = hold_trst;
    // Test clock, mode and data stand at their idle levels between bursts.
    always @(negedge clk) begin
        tck <= run ? ~tck : 1'b0;
        tms <= run ? ~tms : 1'b1;
        tdi <= run ? ~tdi : 1'b0;
    end
endmodule : jtag_prog_model

// *** sim/sysctrl_reset_suspend_ctrl_tb.sv ***
// Self-checking bench for the reset release and suspend control.
`timescale 1ns/100ps
module sysctrl_reset_suspend_ctrl_tb;
    localparam int NG = 20;
    localparam int GR = 30;
    logic clk       = 1'b0;
    logic arst_n    = 1'b0;
    logic dev_rst_n = 1'b1;
    logic img_load  = 1'b0;
    logic img_bit   = 1'b0;
    logic prog      = 1'b0;
    logic run       = 1'b0;
    logic hold_trst = 1'b0;
    logic tck, tms, tdi, trst_b, por_n, rdy, fab_rst_n, gar, susp, acc, utap, utck, utms, utdi;
    int   n_fail     = 0;
    int   num_checks = 0;

    always #20 clk = ~clk;

    jtag_prog_model u_prog (.clk(clk), .run(run), .hold_trst(hold_trst), .tck(tck), .tms(tms), .tdi(tdi),
                            .test_reset_pin_b(trst_b));

    sysctrl_reset_suspend_ctrl #(.NOGRST_CYCLES(NG), .GRST_CYCLES(GR)) dut (
        .clk(clk), .arst_n(arst_n), .device_reset_pin_n(dev_rst_n), .test_reset_pin_b(trst_b),
        .image_load(img_load), .image_suspend_bit(img_bit), .programming(prog), .tck(tck), .tms(tms),
        .tdi(tdi), .internal_por_n(por_n), .fabric_ready(rdy), .fabric_reset_macro(fab_rst_n),
        .global_async_reset(gar), .suspended(susp), .jtag_accept(acc), .user_tap_extension(utap),
        .user_tck(utck), .user_tms(utms), .user_tdi(utdi));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task automatic power_up(input logic t);
        arst_n = 1'b0;
        hold_trst = t;
        repeat (4) @(negedge clk);
        arst_n = 1'b1;
        repeat (2) @(negedge clk);
    endtask : power_up

    task automatic load(input logic b);
        img_bit = b;
        img_load = 1'b1;
        @(negedge clk);
        img_load = 1'b0;
    endtask : load

    task automatic dev_reset;
        int n;
        int rdy_at;
        int bad;
        n = 0;
        rdy_at = 0;
        bad = 0;
        dev_rst_n = 1'b0;
        repeat (2) @(negedge clk);
        check(por_n, 1'b0);
        dev_rst_n = 1'b1;
        while (por_n !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
            if (rdy === 1'b1 && rdy_at == 0) rdy_at = n;
            if (por_n !== 1'b1 && (fab_rst_n !== 1'b0 || gar !== 1'b1)) bad++;
        end
        check(n >= GR && n <= GR + 2, 1'b1);
        check(rdy_at >= NG && rdy_at <= NG + 2, 1'b1);
        check(bad, 0);
        repeat (2) @(negedge clk);
        check(fab_rst_n, 1'b1);
        repeat (20) @(negedge clk);
    endtask : dev_reset

    task automatic burst(output int hi);
        hi = 0;
        run <= 1'b1;
        repeat (8) begin
            @(negedge clk);
            if (utck === 1'b1) hi++;
            if (utdi === 1'b1) hi++;
            if (utms === 1'b0) hi++;
        end
        run <= 1'b0;
        @(negedge clk);
    endtask : burst

    task automatic t_release;
        power_up(1'b0);
        dev_reset();
        check(susp, 1'b0);
        check(gar, 1'b0);
        $display("test release done");
    endtask : t_release

    task automatic t_suspend;
        int hi;
        load(1'b1);
        dev_reset();
        check(susp, 1'b1);
        burst(hi);
        check(hi, 0);
        check(acc, 1'b0);
        hold_trst = 1'b1;
        burst(hi);
        check(hi, 0);
        hold_trst = 1'b0;
        dev_reset();
        check(susp, 1'b1);
        power_up(1'b0);
        repeat (60) @(negedge clk);
        check(susp, 1'b1);
        load(1'b0);
        repeat (3) @(negedge clk);
        check(susp, 1'b0);
        burst(hi);
        check(hi > 0, 1'b1);
        $display("test suspend done");
    endtask : t_suspend

    task automatic t_trst_high;
        int hi;
        load(1'b1);
        power_up(1'b1);
        dev_reset();
        check(susp, 1'b0);
        burst(hi);
        check(hi > 0, 1'b1);
        check(utap, 1'b1);
        prog = 1'b1;
        repeat (2) @(negedge clk);
        check(gar, 1'b1);
        check(utap, 1'b0);
        prog = 1'b0;
        $display("test test-reset high done");
    endtask : t_trst_high

    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        tally_and_finish();
    end

    initial begin
        t_release();
        t_suspend();
        t_trst_high();
        tally_and_finish();
    end
endmodule : sysctrl_reset_suspend_ctrl_tb
